// [mic_irq_ctrl.sv]
// Interrupt control unit: sources, enables, priorities and flags for the CPU core.
// Assumes peripherals and the CPU core share aclk; external pins arrive asynchronously.
//
// Summary of operation
// - Two active-low pins, edge or level
// - ADC, SPI, two radio, wakeup sources
// - Global allow masks all CPU requests when clear; irq is not masked
// - Classic enable bits per source
// - Reserved bits read fixed values
// - Classic priority bits, one means high
// - Radio 2 rising edge sets flag
// - Radio 1 rising edge sets flag
// - SPI byte done sets flag
// - ADC done rising edge sets flag
// - Software set raises request like hardware
// - Extended sources use separate registers
// - Extended enable bits per source
// - Extended priority bits, top reads one
// - Wakeup flag set, software clear/set
// - Vector addresses for extended sources
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

module mic_irq_ctrl
  import mic_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External request pins
  input  wire logic        external_request_0_low,
  input  wire logic        external_request_1_low,
  input  wire logic [1:0]  ext_pin_ack,
  // Classic source flags
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        timer2_overflow_flag,
  input  wire logic        timer2_external_flag,
  input  wire logic        uart_send_done_flag,
  input  wire logic        uart_recv_done_flag,
  // Extended source signals
  input  wire logic        adc_done_source,
  input  wire logic        spi_done_source,
  input  wire logic        radio_pkt_ready_1,
  input  wire logic        radio_pkt_ready_2,
  input  wire logic        wakeup_event,
  // CPU core requests
  output logic [10:0]      cpu_irq_req,
  output logic [10:0]      cpu_irq_high,
  output logic             cpu_irq_pending,
  output logic [7:0]       cpu_irq_vector,
  output logic             cpu_irq_vector_high,
  // Event interrupt
  output logic             irq
);

  // Map a byte address to a register index, 8'hff when out of range
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    reg_index = (a[11:10] == 2'b00) ? a[9:2] : 8'hff;
  endfunction

  // True when an index names a register
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == IDX_EXT_IRQ_FLAGS) || (i == IDX_STD_IRQ_ENABLES) ||
                (i == IDX_STD_IRQ_PRIORITY) || (i == IDX_EXT_IRQ_CONTROL) ||
                (i == IDX_EXT_IRQ_ENABLES) || (i == IDX_EXT_IRQ_RANKS) ||
                (i == IDX_EVT_STATUS) || (i == IDX_EVT_MASK) || (i == IDX_PIN_MODE);
  endfunction

  // Vector address of a source in natural order
  function automatic logic [7:0] vector_of(input logic [3:0] s);
    logic [7:0] v;
    v = (s < 4'(NUM_STD)) ? VEC_STD_BASE + 8'(s) * VEC_STEP
                          : VEC_EXT_BASE + 8'(s - 4'(NUM_STD)) * VEC_STEP;
    vector_of = v;
  endfunction

  // Bus state
  logic             aw_hold_r;
  logic [11:0]      aw_addr_r;
  logic             w_hold_r;
  logic [7:0]       w_data_r;
  logic             w_strb_r;
  logic             bvalid_r;
  logic [1:0]       bresp_r;
  logic             rvalid_r;
  logic [31:0]      rdata_r;
  logic [1:0]       rresp_r;
  logic             wr_go;
  logic [7:0]       wr_idx;
  logic             wr_en;
  logic             rd_go;
  logic [7:0]       rd_idx;
  logic [7:0]       rd_val;

  // Interrupt registers
  logic             global_allow_r;
  logic [5:0]       std_allow_r;
  logic [5:0]       std_rank_r;
  logic [4:0]       ext_allow_r;
  logic [4:0]       ext_rank_r;
  logic [3:0]       ext_flag_r;
  logic [3:0]       ext_flag_nxt;
  logic             wakeup_flag_r;
  logic             wakeup_flag_nxt;
  logic [4:0]       evt_status_r;
  logic [4:0]       evt_status_nxt;
  logic [4:0]       evt_mask_r;
  logic [1:0]       pin_edge_mode_r;

  // Source tracking
  logic [4:0]       src_now;
  logic [4:0]       src_prev_r;
  logic [4:0]       src_rise;
  logic [1:0]       pin_raw;
  logic [1:0]       pin_meta_r;
  logic [1:0]       pin_sync_r;
  logic [1:0]       pin_prev_r;
  logic [1:0]       pin_edge_r;
  logic [1:0]       pin_req;

  // Request logic
  logic [10:0]      raw_req;
  logic [10:0]      allow_all;
  logic [10:0]      rank_all;
  logic [10:0]      live_req;
  logic             sel_found;
  logic             sel_high;
  logic [3:0]       sel_idx;

  // Write channel: address and data are taken in either order
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_go         = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_idx        = reg_index(aw_addr_r);
  assign wr_en         = wr_go && w_strb_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_strb_r <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered on the next edge
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rd_go         = s_axi_arvalid && !rvalid_r;
  assign rd_idx        = reg_index(s_axi_araddr);

  // Read values with fixed reserved bits
  always_comb begin
    rd_val = 8'h00;
    case (rd_idx)
      IDX_EXT_IRQ_FLAGS:    rd_val = {ext_flag_r, 4'h0} | EXT_FLAGS_FIXED;
      IDX_STD_IRQ_ENABLES:  rd_val = {global_allow_r, 1'b0, std_allow_r};
      IDX_STD_IRQ_PRIORITY: rd_val = {2'b00, std_rank_r} | STD_PRIO_FIXED;
      IDX_EXT_IRQ_CONTROL:  rd_val = {4'h0, wakeup_flag_r, 3'h0} | EXT_CTRL_FIXED;
      IDX_EXT_IRQ_ENABLES:  rd_val = {3'h0, ext_allow_r} | EXT_EN_FIXED;
      IDX_EXT_IRQ_RANKS:    rd_val = {3'h0, ext_rank_r} | EXT_RANK_FIXED;
      IDX_EVT_STATUS:       rd_val = {3'h0, evt_status_r};
      IDX_EVT_MASK:         rd_val = {3'h0, evt_mask_r};
      IDX_PIN_MODE:         rd_val = {6'h00, pin_edge_mode_r};
      default:              rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_val};
      rresp_r  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Classic enable and priority registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_allow_r <= RST_REG[GLOBAL_ALLOW_BIT];
      std_allow_r    <= RST_REG[5:0];
    end else if (wr_en && wr_idx == IDX_STD_IRQ_ENABLES) begin
      global_allow_r <= w_data_r[GLOBAL_ALLOW_BIT];
      std_allow_r    <= w_data_r[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      std_rank_r <= RST_REG[5:0];
    end else if (wr_en && wr_idx == IDX_STD_IRQ_PRIORITY) begin
      std_rank_r <= w_data_r[5:0];
    end
  end

  // Extended enable and priority registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_allow_r <= RST_REG[4:0];
    end else if (wr_en && wr_idx == IDX_EXT_IRQ_ENABLES) begin
      ext_allow_r <= w_data_r[4:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_rank_r <= RST_REG[4:0];
    end else if (wr_en && wr_idx == IDX_EXT_IRQ_RANKS) begin
      ext_rank_r <= w_data_r[4:0];
    end
  end

  // Rising edges of internal sources
  assign src_now  = {wakeup_event, radio_pkt_ready_2, radio_pkt_ready_1, spi_done_source, adc_done_source};
  assign src_rise = src_now & ~src_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_r <= 5'h00;
    end else begin
      src_prev_r <= src_now;
    end
  end

  // Extended flags; a hardware set wins over a software clear
  always_comb begin
    ext_flag_nxt = ext_flag_r;
    if (wr_en && wr_idx == IDX_EXT_IRQ_FLAGS) begin
      ext_flag_nxt = w_data_r[7:EXT_FLAG_LSB];
    end
    ext_flag_nxt[3] = ext_flag_nxt[3] | src_rise[3];
    ext_flag_nxt[2] = ext_flag_nxt[2] | src_rise[2];
    ext_flag_nxt[1] = ext_flag_nxt[1] | src_rise[1];
    ext_flag_nxt[0] = ext_flag_nxt[0] | src_rise[0];
  end

  always_comb begin
    wakeup_flag_nxt = wakeup_flag_r;
    if (wr_en && wr_idx == IDX_EXT_IRQ_CONTROL) begin
      wakeup_flag_nxt = w_data_r[WAKEUP_FLAG_BIT];
    end
    wakeup_flag_nxt = wakeup_flag_nxt | src_rise[4];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_flag_r    <= RST_REG[3:0];
      wakeup_flag_r <= RST_REG[WAKEUP_FLAG_BIT];
    end else begin
      ext_flag_r    <= ext_flag_nxt;
      wakeup_flag_r <= wakeup_flag_nxt;
    end
  end

  // Event status, cleared by reading it; a new event wins
  always_comb begin
    evt_status_nxt = evt_status_r;
    if (rd_go && rd_idx == IDX_EVT_STATUS) begin
      evt_status_nxt = 5'h00;
    end
    evt_status_nxt = evt_status_nxt | src_rise;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_r <= RST_REG[4:0];
    end else begin
      evt_status_r <= evt_status_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_r <= RST_REG[4:0];
    end else if (wr_en && wr_idx == IDX_EVT_MASK) begin
      evt_mask_r <= w_data_r[4:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status_nxt & evt_mask_r);
    end
  end

  // Pin sense mode, one bit per pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_edge_mode_r <= RST_REG[1:0];
    end else if (wr_en && wr_idx == IDX_PIN_MODE) begin
      pin_edge_mode_r <= w_data_r[1:0];
    end
  end

  // External pins: synchronise, then level or latched falling edge
  assign pin_raw = {external_request_1_low, external_request_0_low};

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_meta_r[gp] <= 1'b1;
          pin_sync_r[gp] <= 1'b1;
          pin_prev_r[gp] <= 1'b1;
        end else begin
          pin_meta_r[gp] <= pin_raw[gp];
          pin_sync_r[gp] <= pin_meta_r[gp];
          pin_prev_r[gp] <= pin_sync_r[gp];
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_edge_r[gp] <= 1'b0;
        end else if (pin_prev_r[gp] && !pin_sync_r[gp]) begin
          pin_edge_r[gp] <= 1'b1;
        end else if (ext_pin_ack[gp] || !pin_edge_mode_r[gp]) begin
          pin_edge_r[gp] <= 1'b0;
        end
      end

      assign pin_req[gp] = pin_edge_mode_r[gp] ? pin_edge_r[gp] : !pin_sync_r[gp];
    end
  endgenerate

  // Sources in natural order; extended sources use their own registers
  assign raw_req = {wakeup_flag_r, ext_flag_r,
                    timer2_overflow_flag | timer2_external_flag,
                    uart_send_done_flag | uart_recv_done_flag,
                    timer1_overflow_flag, pin_req[1],
                    timer0_overflow_flag, pin_req[0]};
  assign allow_all = {ext_allow_r, std_allow_r};
  assign rank_all  = {ext_rank_r, std_rank_r};
  assign live_req  = raw_req & allow_all & {NUM_SRC{global_allow_r}};

  // Pick the pending source: high rank first, then natural order
  always_comb begin
    sel_found = 1'b0;
    sel_high  = 1'b0;
    sel_idx   = 4'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (live_req[i] && rank_all[i] && !(sel_found && sel_high)) begin
        sel_found = 1'b1;
        sel_high  = 1'b1;
        sel_idx   = 4'(i);
      end else if (live_req[i] && !sel_found) begin
        sel_found = 1'b1;
        sel_idx   = 4'(i);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq_req         <= 11'h000;
      cpu_irq_high        <= 11'h000;
      cpu_irq_pending     <= 1'b0;
      cpu_irq_vector      <= 8'h00;
      cpu_irq_vector_high <= 1'b0;
    end else begin
      cpu_irq_req         <= live_req;
      cpu_irq_high        <= live_req & rank_all;
      cpu_irq_pending     <= sel_found;
      cpu_irq_vector      <= sel_found ? vector_of(sel_idx) : 8'h00;
      cpu_irq_vector_high <= sel_found && sel_high;
    end
  end

endmodule

// [mic_pkg.sv]
// Constants for the CPU interrupt control unit.
// Assumes a 32-bit AXI4-Lite register bus; each register sits at byte address four times its index.
package mic_pkg;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_EXT_IRQ_FLAGS    = 8'h91;
  localparam logic [7:0] IDX_STD_IRQ_ENABLES  = 8'ha8;
  localparam logic [7:0] IDX_STD_IRQ_PRIORITY = 8'hb8;
  localparam logic [7:0] IDX_EXT_IRQ_CONTROL  = 8'hd8;
  localparam logic [7:0] IDX_EXT_IRQ_ENABLES  = 8'he8;
  localparam logic [7:0] IDX_EXT_IRQ_RANKS    = 8'hf8;
  localparam logic [7:0] IDX_EVT_STATUS       = 8'h20;
  localparam logic [7:0] IDX_EVT_MASK         = 8'h21;
  localparam logic [7:0] IDX_PIN_MODE         = 8'h22;

  // Fixed read values of reserved bits
  localparam logic [7:0] EXT_FLAGS_FIXED = 8'h08;
  localparam logic [7:0] STD_PRIO_FIXED  = 8'h80;
  localparam logic [7:0] EXT_CTRL_FIXED  = 8'h40;
  localparam logic [7:0] EXT_EN_FIXED    = 8'he0;
  localparam logic [7:0] EXT_RANK_FIXED  = 8'he0;

  // Field positions
  localparam int GLOBAL_ALLOW_BIT = 7;
  localparam int EXT_FLAG_LSB     = 4;
  localparam int WAKEUP_FLAG_BIT  = 3;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Source count and split between classic and extended sources
  localparam int NUM_SRC = 11;
  localparam int NUM_STD = 6;
  localparam int NUM_EXT = 5;

  // Vector addresses
  localparam logic [7:0] VEC_STD_BASE = 8'h03;
  localparam logic [7:0] VEC_EXT_BASE = 8'h43;
  localparam logic [7:0] VEC_STEP     = 8'h08;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// [mic_irq_ctrl_sva.sv]
// Port checker for the interrupt control unit.
// Assumes it is bound to mic_irq_ctrl and sees only its ports.
`timescale 1ns/1ps

module mic_irq_ctrl_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Classic sources
  input wire logic        timer0_overflow_flag,
  input wire logic        uart_send_done_flag,
  input wire logic        uart_recv_done_flag,
  // CPU side
  input wire logic [10:0] cpu_irq_req,
  input wire logic [10:0] cpu_irq_high,
  input wire logic        cpu_irq_pending,
  input wire logic [7:0]  cpu_irq_vector,
  input wire logic        cpu_irq_vector_high,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_high_needs_req: assert property ((cpu_irq_high & ~cpu_irq_req) == 11'h000)
    else $error("high priority without request");
  a_vec_high_src: assert property (cpu_irq_vector_high |-> cpu_irq_high != 11'h000)
    else $error("high vector without high request");
  a_vec_idle: assert property (!cpu_irq_pending |-> cpu_irq_vector == 8'h00)
    else $error("vector while idle");
  a_adc_vector: assert property (cpu_irq_vector == 8'h43 |-> cpu_irq_req[6])
    else $error("adc vector without request");
  a_wake_vector: assert property (cpu_irq_vector == 8'h63 |-> cpu_irq_req[10])
    else $error("wakeup vector without request");
  a_timer0_cause: assert property (cpu_irq_req[1] |-> $past(timer0_overflow_flag))
    else $error("timer0 request without flag");
  a_uart_cause: assert property (cpu_irq_req[4] |-> $past(uart_send_done_flag) || $past(uart_recv_done_flag))
    else $error("uart request without flag");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  c_adc_high: cover property (cpu_irq_vector == 8'h43 && cpu_irq_vector_high);
  c_irq_rise: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind mic_irq_ctrl mic_irq_ctrl_sva u_sva (.*);

// [mic_periph_model.sv]
// Peripheral model: raises the five extended source lines on command.
// Assumes one-cycle fire pulses from the bench; each line stays high three cycles.
`timescale 1ns/1ps

module mic_periph_model (
  // Clock
  input wire logic        aclk,
  // Commands
  input wire logic [4:0]  fire,
  // Source lines: wakeup, radio2, radio1, spi, adc
  output logic [4:0]      src
);
  logic [4:0] d1_r = 5'h00;
  logic [4:0] d2_r = 5'h00;
  logic [4:0] d3_r = 5'h00;

  always_ff @(posedge aclk) begin
    d1_r <= fire;
    d2_r <= d1_r;
    d3_r <= d2_r;
  end
  assign src = d1_r | d2_r | d3_r;
endmodule

// [tb_mcu_interrupt_control_unit.sv]
// Testbench for the interrupt control unit.
// Assumes mic_pkg, mic_irq_ctrl, the checker and the peripheral model compile first.
`timescale 1ns/1ps

module tb_mcu_interrupt_control_unit import mic_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        external_request_0_low = 1'b1, external_request_1_low = 1'b1;
  logic [1:0]  ext_pin_ack = 2'h0;
  logic        timer0_overflow_flag = 1'b0, timer1_overflow_flag = 1'b0;
  logic        timer2_overflow_flag = 1'b0, timer2_external_flag = 1'b0;
  logic        uart_send_done_flag = 1'b0, uart_recv_done_flag = 1'b0;
  logic [4:0]  fire = 5'h00;
  wire         adc_done_source, spi_done_source, radio_pkt_ready_1, radio_pkt_ready_2, wakeup_event;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [10:0] cpu_irq_req, cpu_irq_high;
  logic [7:0]  cpu_irq_vector;
  logic        cpu_irq_pending, cpu_irq_vector_high, irq;
  int          n_errors = 0, total_checks = 0, cycles = 0;
  // Address, reset read, write data, read back, response
  logic [37:0] rows [9] = '{
    {12'h244, 8'h08, 8'h0f, 8'h08, 2'b00}, {12'h2a0, 8'h00, 8'h7f, 8'h3f, 2'b00},
    {12'h2e0, 8'h80, 8'h40, 8'h80, 2'b00}, {12'h360, 8'h40, 8'h00, 8'h40, 2'b00},
    {12'h3a0, 8'he0, 8'h1f, 8'hff, 2'b00}, {12'h3e0, 8'he0, 8'h00, 8'he0, 2'b00},
    {12'h084, 8'h00, 8'h1f, 8'h1f, 2'b00}, {12'h088, 8'h00, 8'h00, 8'h00, 2'b00},
    {12'hffc, 8'h00, 8'h00, 8'h00, 2'b10}};

  mic_irq_ctrl dut (.*);
  mic_periph_model model (.aclk(aclk), .fire(fire),
    .src({wakeup_event, radio_pkt_ready_2, radio_pkt_ready_1, spi_done_source, adc_done_source}));

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("mismatch run length expected 5000 seen %0d", cycles);
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok, bv;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok  = s_axi_wvalid && s_axi_wready;
      bv    = s_axi_bvalid;
      b_ok  = bv && s_axi_bready;
      r     = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !b_ok;
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_ok, r_ok, rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      rv    = s_axi_rvalid;
      r_ok  = rv && s_axi_rready;
      d     = s_axi_rdata;
      r     = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !r_ok;
    end
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rdc(rows[i][37:26], {24'h0, rows[i][25:18]}, rows[i][1:0]);
      wr(rows[i][37:26], rows[i][17:10], rows[i][1:0]);
      rdc(rows[i][37:26], {24'h0, rows[i][9:2]}, rows[i][1:0]);
    end
    $display("register table test done");
    @(posedge aclk);
    timer0_overflow_flag <= 1'b1;
    timer1_overflow_flag <= 1'b1;
    timer2_external_flag <= 1'b1;
    uart_recv_done_flag  <= 1'b1;
    settle(3);
    chk("req global off", 32'h0, {21'h0, cpu_irq_req});
    wr(12'h2a0, 8'hbf, RESP_OKAY);
    settle(2);
    chk("req classic", 32'h3a, {21'h0, cpu_irq_req});
    chk("vector classic", 32'h0b, {24'h0, cpu_irq_vector});
    wr(12'h2e0, 8'h08, RESP_OKAY);
    settle(2);
    chk("high classic", 32'h8, {21'h0, cpu_irq_high});
    chk("vector high", 32'h31b, {22'h0, cpu_irq_pending, cpu_irq_vector_high, cpu_irq_vector});
    rdc(12'h2e0, 32'h88, RESP_OKAY);
    @(posedge aclk);
    timer0_overflow_flag <= 1'b0;
    timer1_overflow_flag <= 1'b0;
    timer2_external_flag <= 1'b0;
    uart_recv_done_flag  <= 1'b0;
    external_request_0_low <= 1'b0;
    external_request_1_low <= 1'b0;
    settle(4);
    chk("req pins", 32'h5, {21'h0, cpu_irq_req});
    @(posedge aclk);
    external_request_0_low <= 1'b1;
    external_request_1_low <= 1'b1;
    $display("classic source test done");
    for (int k = 0; k < 5; k++) begin
      @(posedge aclk);
      fire <= 5'(1 << k);
      @(posedge aclk);
      fire <= 5'h00;
      settle(4);
      chk("req extended", 32'h40 << k, {21'h0, cpu_irq_req});
      chk("vector extended", 32'h43 + 8 * k, {24'h0, cpu_irq_vector});
      chk("irq set", 32'h1, {31'h0, irq});
      rdc(12'h080, 32'h1 << k, RESP_OKAY);
      settle(0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rdc(12'h244, (k < 4) ? (32'h08 | (32'h10 << k)) : 32'h08, RESP_OKAY);
      rdc(12'h360, (k == 4) ? 32'h48 : 32'h40, RESP_OKAY);
      wr(12'h244, 8'h00, RESP_OKAY);
      wr(12'h360, 8'h00, RESP_OKAY);
    end
    $display("extended source test done");
    wr(12'h244, 8'h10, RESP_OKAY);
    wr(12'h360, 8'h08, RESP_OKAY);
    settle(2);
    chk("req soft set", 32'h440, {21'h0, cpu_irq_req});
    wr(12'h2a0, 8'h3f, RESP_OKAY);
    settle(2);
    chk("req ext global off", 32'h0, {21'h0, cpu_irq_req});
    wr(12'h2a0, 8'h80, RESP_OKAY);
    wr(12'h3a0, 8'h01, RESP_OKAY);
    wr(12'h3e0, 8'h11, RESP_OKAY);
    settle(2);
    chk("req ext enable", 32'h40, {21'h0, cpu_irq_req});
    chk("high ext", 32'h40, {21'h0, cpu_irq_high});
    $display("software set test done");
    wr(12'h084, 8'h00, RESP_OKAY);
    @(posedge aclk);
    fire <= 5'h04;
    @(posedge aclk);
    fire <= 5'h00;
    settle(4);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdc(12'h080, 32'h04, RESP_OKAY);
    $display("event mask test done");
    wr(12'h2a0, 8'h81, RESP_OKAY);
    wr(12'h088, 8'h01, RESP_OKAY);
    @(posedge aclk);
    external_request_0_low <= 1'b0;
    @(posedge aclk);
    external_request_0_low <= 1'b1;
    settle(5);
    chk("req pin edge", 32'h41, {21'h0, cpu_irq_req});
    @(posedge aclk);
    ext_pin_ack <= 2'h1;
    @(posedge aclk);
    ext_pin_ack <= 2'h0;
    settle(2);
    chk("req pin ack", 32'h40, {21'h0, cpu_irq_req});
    $display("pin edge test done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(0);
    chk("req after reset", 32'h0, {20'h0, cpu_irq_pending, cpu_irq_req});
    rdc(12'h244, 32'h08, RESP_OKAY);
    rdc(12'h3a0, 32'he0, RESP_OKAY);
    $display("reset test done");
    test_done();
  end
endmodule
